// File: include/mrs_defines.vh
`ifndef MRS_DEFINES_VH
`define MRS_DEFINES_VH

// Reset cause codes, one-hot, held in the last-cause register.
`define MRS_CAUSE_W        5
`define MRS_CAUSE_PIN      5'h01
`define MRS_CAUSE_SUPPLY   5'h02
`define MRS_CAUSE_WATCHDOG 5'h04
`define MRS_CAUSE_STK_OVF  5'h08
`define MRS_CAUSE_STK_UNF  5'h10

// Settling wait: prescale divide and timer-1 count.
`define MRS_SETTLE_DIV     128
`define MRS_SETTLE_COUNT   256

// Values loaded into hardware state.
`define MRS_PC_RESET       16'h0000
`define MRS_SP_RESET       4'h5
`define MRS_ITMR_WDT       8'h40
`define MRS_TCOUNT_RESET   8'h00
`define MRS_TMOD_RESET     8'hFF
`define MRS_CONV_RESET     8'h00

// Control register field positions.
`define MRS_CTL_T1REQ      0
`define MRS_CTL_T1EN       1
`define MRS_CTL_ITREQ      2
`define MRS_CTL_INTPIN     3
`define MRS_CTL_W          8

// Register map for the plain register port.
`define MRS_ADDR_W         4
`define MRS_REG_STATUS     4'h0
`define MRS_REG_CAUSE      4'h1
`define MRS_REG_CONTROL    4'h2
`define MRS_REG_TMRS       4'h3
`define MRS_REG_SETTLE     4'h4

`endif

// File: design/mrs_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for a bus of asynchronous levels.
module mrs_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input  wire             clock,
  input  wire             reset,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] stage1;

  // The first stage feeds only the second, so metastability stays inside.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      stage1 <= INIT;
      dout   <= INIT;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // mrs_sync

// File: design/mrs_settle_timer.v
`timescale 1ns/1ps
`include "mrs_defines.vh"
// Settling-interval counter: divides the clock by DIV, counts COUNT ticks.
module mrs_settle_timer #(
  parameter DIV   = `MRS_SETTLE_DIV,
  parameter COUNT = `MRS_SETTLE_COUNT
) (
  input  wire       clock,
  input  wire       reset,
  input  wire       start,
  output reg        busy,
  output reg        done,
  output reg  [8:0] ticks
);

  reg [7:0] prescale;

  // Prescaler and tick counter run only while busy; start restarts both.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      prescale <= 8'h00;
      ticks    <= 9'h000;
      busy     <= 1'b0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        prescale <= 8'h00;
        ticks    <= 9'h000;
        busy     <= 1'b1;
      end else if (busy) begin
        if (prescale == DIV[7:0] - 8'h01) begin
          prescale <= 8'h00;
          if (ticks == COUNT[8:0] - 9'h001) begin
            ticks <= COUNT[8:0];
            busy  <= 1'b0;
            done  <= 1'b1;
          end else begin
            ticks <= ticks + 9'h001;
          end
        end else begin
          prescale <= prescale + 8'h01;
        end
      end
    end
  end

endmodule // mrs_settle_timer

// File: design/mrs_reset_seq.v
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "mrs_defines.vh"
// Contract
// R1: Reset is accepted from the pin, the supply monitor, watchdog overflow and stack overflow or underflow.
// R2: The supply-monitor source only acts when the build option enables it.
// R3: After the pin returns high the oscillator starts, the settling wait runs, and execution starts at 0000H.
// R4: A supply-monitor reset follows the same start, wait and zero-address sequence as the pin.
// R5: Watchdog and stack resets skip the wait and start at 0000H once initialization ends.
// R6: The settling wait ends when timer 1 has counted the clock divided by 128 for 256 ticks.
// R7: All resets make port pins inputs; pin or supply resets clear port and serial latches, others leave them.
// R8: System registers clear on every reset; only a pin or supply reset in standby keeps window, data memory and shift register.
// R9: Pin or supply resets load SP 5H, set timer-1 request, enable and interval request, copy the interrupt pin, clear the rest; other resets change only SP and that pin bit.
// R10: The interval counter is left unchanged except after watchdog overflow, when it becomes 40H.
// R11: Timer counts reset to 00H and modulo registers to FFH, timer-1 count kept on internal resets, converter result to 00H always.
module mrs_reset_seq #(
  parameter SUPPLY_MONITOR = 1,
  parameter DIV            = `MRS_SETTLE_DIV,
  parameter COUNT          = `MRS_SETTLE_COUNT
) (
  input  wire                       clock,
  input  wire                       reset,
  input  wire                       reset_pin_n,
  input  wire                       supply_monitor_reset,
  input  wire                       watchdog_overflow,
  input  wire                       stack_overflow,
  input  wire                       stack_underflow,
  input  wire                       standby,
  input  wire                       interrupt_pin,
  input  wire [`MRS_ADDR_W-1:0]     reg_addr,
  input  wire [7:0]                 reg_wdata,
  input  wire                       reg_write,
  input  wire                       reg_read,
  output reg  [7:0]                 reg_rdata,
  output reg                        oscillator_enable,
  output reg                        cpu_run,
  output reg                        core_reset,
  output reg  [15:0]                program_counter,
  output reg                        port_output_enable,
  output reg                        latch_clear,
  output reg                        retain_memory,
  output reg                        system_reg_clear,
  output reg  [3:0]                 stack_pointer,
  output reg  [`MRS_CTL_W-1:0]      control_bits,
  output reg                        control_load,
  output reg                        interval_load,
  output reg  [7:0]                 interval_value,
  output reg  [7:0]                 timer0_count,
  output reg  [7:0]                 timer1_count,
  output reg  [7:0]                 timer0_modulo,
  output reg  [7:0]                 timer1_modulo,
  output reg                        timer1_clear_signal,
  output reg  [7:0]                 converter_result_register
);

  ////////////////////////////////////////////////////////////////////////////
  // Source synchronisation.

  localparam S_RUN    = 4'b0001;
  localparam S_HOLD   = 4'b0010;
  localparam S_SETTLE = 4'b0100;
  localparam S_INIT   = 4'b1000;

  wire [5:0] sync_in;
  wire [5:0] sync_out;
  wire       pin_low;
  wire       supply_low;
  wire       wdt_evt;
  wire       ovf_evt;
  wire       unf_evt;
  wire       int_level;
  wire       ext_active;
  wire       int_evt;
  wire       settle_busy;
  wire       settle_done;
  wire [8:0] settle_ticks;
  wire       cause_wr;

  reg  [3:0]             state;
  reg  [3:0]             next_state;
  reg  [`MRS_CAUSE_W-1:0] cause;
  reg  [`MRS_CAUSE_W-1:0] cause_sticky;
  reg                    standby_seen;
  reg                    settle_start;
  reg                    hold_cpu;

  // One-hot code of an external cause; the pin wins over the monitor.
  function [`MRS_CAUSE_W-1:0] ext_cause;
    input pin;
    begin
      ext_cause = pin ? `MRS_CAUSE_PIN : `MRS_CAUSE_SUPPLY;
    end
  endfunction

  // One-hot code of an internal cause; a watchdog overflow ranks first.
  function [`MRS_CAUSE_W-1:0] int_cause;
    input wdt;
    input ovf;
    begin
      int_cause = wdt ? `MRS_CAUSE_WATCHDOG :
                  (ovf ? `MRS_CAUSE_STK_OVF : `MRS_CAUSE_STK_UNF);
    end
  endfunction

  assign sync_in = {interrupt_pin, stack_underflow, stack_overflow,
                    watchdog_overflow, supply_monitor_reset, ~reset_pin_n};

  // Pin-side levels cross in; reset state assumes the pin is asserted.
  mrs_sync #(
    .WIDTH (6),
    .INIT  (6'h01)
  ) u_sync (
    .clock (clock),
    .reset (reset),
    .din   (sync_in),
    .dout  (sync_out)
  );

  assign pin_low    = sync_out[0];
  // Without the build option the monitor input is ignored outright.
  assign supply_low = (SUPPLY_MONITOR != 0) & sync_out[1]; // see R2
  assign wdt_evt    = sync_out[2];
  assign ovf_evt    = sync_out[3];
  assign unf_evt    = sync_out[4];
  assign int_level  = sync_out[5];
  assign ext_active = pin_low | supply_low; // see R1
  assign int_evt    = wdt_evt | ovf_evt | unf_evt; // see R1
  // Write decode of the cause register, shared by every branch below.
  assign cause_wr   = reg_write && (reg_addr == `MRS_REG_CAUSE);

  mrs_settle_timer #(
    .DIV   (DIV),
    .COUNT (COUNT)
  ) u_settle (
    .clock (clock),
    .reset (reset),
    .start (settle_start),
    .busy  (settle_busy),
    .done  (settle_done),
    .ticks (settle_ticks)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // External sources dominate: an internal event during a hold is absorbed.
  always @* begin
    next_state   = state;
    settle_start = 1'b0;
    case (state)
      S_RUN: begin
        if (ext_active) begin
          next_state = S_HOLD;
        end else if (int_evt) begin
          next_state = S_INIT; // see R5
        end
      end
      S_HOLD: begin
        if (!ext_active) begin
          next_state   = S_SETTLE; // see R3 R4
          settle_start = 1'b1;
        end
      end
      S_SETTLE: begin
        if (ext_active) begin
          next_state = S_HOLD;
        end else if (settle_done) begin
          next_state = S_RUN; // see R6
        end
      end
      S_INIT: begin
        if (ext_active) begin
          next_state = S_HOLD;
        end else begin
          next_state = S_RUN;
        end
      end
      default: begin
        next_state = S_HOLD;
      end
    endcase
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= S_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Standby must be noted at the moment an external reset begins, since
  // the standby logic drops its flag as soon as reset takes hold.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      standby_seen <= 1'b0;
      cause        <= `MRS_CAUSE_PIN;
    end else if (state == S_RUN && ext_active) begin
      standby_seen <= standby;
      cause        <= ext_cause(pin_low);
    end else if (state == S_RUN && int_evt) begin
      standby_seen <= 1'b0;
      cause        <= int_cause(wdt_evt, ovf_evt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hardware initialization outputs.

  // Core outputs; during settle the clock runs but the CPU waits; hold stops the oscillator.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      oscillator_enable   <= 1'b0;
      cpu_run             <= 1'b0;
      core_reset          <= 1'b1;
      hold_cpu            <= 1'b1;
      program_counter     <= `MRS_PC_RESET;
      port_output_enable  <= 1'b0;
      latch_clear         <= 1'b1;
      retain_memory       <= 1'b0;
      system_reg_clear    <= 1'b1;
      timer1_clear_signal <= 1'b1;
    end else begin
      oscillator_enable   <= (next_state != S_HOLD); // see R3 R4
      hold_cpu            <= (next_state != S_RUN);
      cpu_run             <= (next_state == S_RUN); // see R5 R6
      core_reset          <= (next_state != S_RUN);
      timer1_clear_signal <= (next_state == S_HOLD);
      if (next_state != S_RUN) begin
        program_counter    <= `MRS_PC_RESET; // see R3 R5
        port_output_enable <= 1'b0; // see R7
        system_reg_clear   <= 1'b1; // see R8
      end else begin
        port_output_enable <= ~hold_cpu & port_output_enable;
        system_reg_clear   <= 1'b0;
      end
      // Latches clear only for the externally caused resets.
      latch_clear   <= (next_state == S_HOLD) |
                       (latch_clear & next_state == S_SETTLE); // see R7
      // Memory, window and shift register survive only a standby reset;
      // on the entry edge the new cause counts, not the previous one.
      if (state == S_RUN) begin
        retain_memory <= ext_active & standby; // see R8
      end else begin
        retain_memory <= (next_state != S_RUN) & standby_seen &
                         (cause[0] | cause[1]); // see R8
      end
    end
  end

  // Control register image and register-file style loads.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      stack_pointer  <= `MRS_SP_RESET;
      control_bits   <= {`MRS_CTL_W{1'b0}};
      control_load   <= 1'b1;
      interval_load  <= 1'b0;
      interval_value <= 8'h00;
    end else begin
      control_load  <= 1'b0;
      interval_load <= 1'b0;
      if (state == S_HOLD || state == S_SETTLE) begin
        stack_pointer                <= `MRS_SP_RESET; // see R9
        control_bits                 <= {`MRS_CTL_W{1'b0}};
        control_bits[`MRS_CTL_T1REQ] <= 1'b1;
        control_bits[`MRS_CTL_T1EN]  <= 1'b1;
        control_bits[`MRS_CTL_ITREQ] <= 1'b1;
        control_bits[`MRS_CTL_INTPIN] <= int_level;
        control_load                 <= 1'b1;
      end else if (state == S_INIT) begin
        // Only SP and the pin bit are written; other bits stay in place.
        stack_pointer                 <= `MRS_SP_RESET; // see R9
        control_bits[`MRS_CTL_INTPIN] <= int_level;
        control_load                  <= 1'b1;
        if (cause == `MRS_CAUSE_WATCHDOG) begin
          interval_load  <= 1'b1; // see R10
          interval_value <= `MRS_ITMR_WDT;
        end
      end
    end
  end

  // Timer and converter reset values.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      timer0_count              <= `MRS_TCOUNT_RESET;
      timer1_count              <= `MRS_TCOUNT_RESET;
      timer0_modulo             <= `MRS_TMOD_RESET;
      timer1_modulo             <= `MRS_TMOD_RESET;
      converter_result_register <= `MRS_CONV_RESET;
    end else if (next_state != S_RUN) begin
      timer0_count              <= `MRS_TCOUNT_RESET; // see R11
      timer0_modulo             <= `MRS_TMOD_RESET;
      timer1_modulo             <= `MRS_TMOD_RESET;
      converter_result_register <= `MRS_CONV_RESET;
      if (next_state != S_INIT && state != S_INIT) begin
        timer1_count <= `MRS_TCOUNT_RESET; // see R11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port.

  // Sticky cause record; writing ones clears, a new cause wins over a clear.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      cause_sticky <= `MRS_CAUSE_PIN;
    end else begin
      if (state == S_RUN && ext_active) begin
        cause_sticky <= cause_wr ?
          ((cause_sticky & ~reg_wdata[4:0]) | ext_cause(pin_low)) :
          (cause_sticky | ext_cause(pin_low));
      end else if (state == S_RUN && int_evt) begin
        cause_sticky <= cause_wr ?
          ((cause_sticky & ~reg_wdata[4:0]) |
           {unf_evt, ovf_evt, wdt_evt, 2'b00}) :
          (cause_sticky | {unf_evt, ovf_evt, wdt_evt, 2'b00});
      end else if (cause_wr) begin
        cause_sticky <= cause_sticky & ~reg_wdata[4:0];
      end
    end
  end

  // Read data appear one cycle after the strobe; unmapped reads give zero.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      if (reg_addr == `MRS_REG_STATUS) begin
        reg_rdata <= {4'h0, state};
      end else if (reg_addr == `MRS_REG_CAUSE) begin
        reg_rdata <= {3'h0, cause_sticky};
      end else if (reg_addr == `MRS_REG_CONTROL) begin
        reg_rdata <= control_bits;
      end else if (reg_addr == `MRS_REG_TMRS) begin
        reg_rdata <= {standby_seen, retain_memory, latch_clear,
                      settle_busy, stack_pointer};
      end else if (reg_addr == `MRS_REG_SETTLE) begin
        reg_rdata <= settle_ticks[8:1];
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // mrs_reset_seq

// File: verification/mrs_reset_props_properties.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Port checker for the reset sequencer.
module mrs_reset_props #(
  parameter DIV   = 2,
  parameter COUNT = 4
) (
  input wire        clock,
  input wire        reset,
  input wire        reset_pin_n,
  input wire        supply_monitor_reset,
  input wire        watchdog_overflow,
  input wire        cpu_run,
  input wire        core_reset,
  input wire [15:0] program_counter,
  input wire        port_output_enable,
  input wire        latch_clear,
  input wire        system_reg_clear,
  input wire [3:0]  stack_pointer,
  input wire        control_load,
  input wire        interval_load,
  input wire [7:0]  interval_value,
  input wire [7:0]  timer0_count,
  input wire [7:0]  timer0_modulo,
  input wire [7:0]  timer1_modulo,
  input wire [7:0]  converter_result_register,
  input wire        timer1_clear_signal,
  input wire        oscillator_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  reg [15:0] settle_cnt;

  // Counts settling cycles; the hold phase is left out so a long pin
  // pulse cannot hide a missing wait.
  always @(posedge clock or posedge reset) begin
    if (reset)
      settle_cnt <= 16'h0000;
    else if (cpu_run)
      settle_cnt <= 16'h0000;
    else if (latch_clear && !timer1_clear_signal)
      settle_cnt <= settle_cnt + 16'h0001;
  end

  sequence s_wdt_hit;
    $rose(watchdog_overflow) && cpu_run && reset_pin_n &&
      !supply_monitor_reset;
  endsequence
  sequence s_quick_init;
    ##[1:6] (core_reset && !latch_clear) ##[1:4] cpu_run;
  endsequence

  a_pc_zero: assert property (core_reset |->
    program_counter == 16'h0000)
    else $error("program counter not zero in reset");
  a_sysreg_ports: assert property (core_reset |->
    system_reg_clear && !port_output_enable)
    else $error("reset without clear or with driven ports");
  a_sp_loaded: assert property ($fell(control_load) |->
    stack_pointer == 4'h5)
    else $error("stack pointer wrong after load");
  a_timer_init: assert property ($fell(core_reset) |->
    timer0_count == 8'h00 && timer0_modulo == 8'hFF &&
    timer1_modulo == 8'hFF && converter_result_register == 8'h00)
    else $error("timer or converter value wrong after reset");
  a_iv_value: assert property (interval_load |->
    interval_value == 8'h40)
    else $error("interval value wrong");
  a_pin_hold: assert property ((!reset_pin_n) [*6] |->
    latch_clear && core_reset && !oscillator_enable)
    else $error("pin reset held without clear");
  a_settle_min: assert property (
    $rose(cpu_run) && $past(latch_clear) |->
    settle_cnt >= DIV * COUNT - 1)
    else $error("settling wait too short");
  a_wdt_fast: assert property (s_wdt_hit |-> s_quick_init)
    else $error("watchdog reset slow or clearing latches");
  a_wdt_iload: assert property (s_wdt_hit |->
    ##[1:6] interval_load)
    else $error("watchdog reset without interval load");
endmodule // mrs_reset_props

bind mrs_reset_seq mrs_reset_props #(.DIV(DIV), .COUNT(COUNT)) i_props (
  .clock(clock), .reset(reset), .reset_pin_n(reset_pin_n),
  .supply_monitor_reset(supply_monitor_reset),
  .watchdog_overflow(watchdog_overflow), .cpu_run(cpu_run),
  .core_reset(core_reset), .program_counter(program_counter),
  .port_output_enable(port_output_enable), .latch_clear(latch_clear),
  .system_reg_clear(system_reg_clear), .stack_pointer(stack_pointer),
  .control_load(control_load), .interval_load(interval_load),
  .interval_value(interval_value), .timer0_count(timer0_count),
  .timer0_modulo(timer0_modulo), .timer1_modulo(timer1_modulo),
  .converter_result_register(converter_result_register),
  .timer1_clear_signal(timer1_clear_signal),
  .oscillator_enable(oscillator_enable));

// File: verification/mrs_reset_source.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Reset pin driver and supply monitor; the pin starts low as at power-up.
module mrs_reset_source (
  input  wire clock,
  output reg  reset_pin_n,
  output reg  supply_monitor_reset
);
  initial begin
    reset_pin_n = 1'b0;
    supply_monitor_reset = 1'b0;
  end

  // Holds the pin low for n clocks, then releases it.
  task pin_pulse(input int n);
    @(posedge clock);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge clock);
    reset_pin_n <= 1'b1;
  endtask

  // A supply dip lasting n clocks.
  task supply_pulse(input int n);
    @(posedge clock);
    supply_monitor_reset <= 1'b1;
    repeat (n) @(posedge clock);
    supply_monitor_reset <= 1'b0;
  endtask
endmodule // mrs_reset_source

// File: verification/mrs_reset_seq_tb.sv
`timescale 1ns/1ps
`define MRS_CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("wrong value t=%0t got %h exp %h", $time, g, e); \
  end end
////////////////////////////////////////////////////////////////////////////
module mrs_reset_seq_tb;
  reg        clock = 1'b0;
  reg        reset = 1'b1;
  reg        watchdog_overflow = 1'b0;
  reg        stack_overflow = 1'b0;
  reg        stack_underflow = 1'b0;
  reg        standby = 1'b0;
  reg        interrupt_pin = 1'b0;
  reg  [3:0] reg_addr = 4'h0;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_write = 1'b0;
  reg        reg_read = 1'b0;
  wire       reset_pin_n;
  wire       supply_monitor_reset;
  wire [7:0] reg_rdata;
  wire [7:0] control_bits;
  wire       cpu_run;
  wire       retain_memory;
  wire       interval_load;
  int        error_cnt = 0;
  int        samples_checked = 0;
  reg  [7:0] exp_q[$];
  reg        rd_pend = 1'b0;
  int        retain_cnt = 0;
  int        iload_cnt = 0;
  int        mark = 0;
  reg [31:0] rng = 32'h00000016;
  reg  [7:0] codes [3] = '{8'h04, 8'h08, 8'h10};

  always #5 clock = ~clock;

  mrs_reset_source i_src (.clock(clock), .reset_pin_n(reset_pin_n),
    .supply_monitor_reset(supply_monitor_reset));

  mrs_reset_seq #(.DIV(2), .COUNT(4)) i_dut (
    .clock(clock), .reset(reset), .reset_pin_n(reset_pin_n),
    .supply_monitor_reset(supply_monitor_reset),
    .watchdog_overflow(watchdog_overflow), .stack_overflow(stack_overflow),
    .stack_underflow(stack_underflow), .standby(standby),
    .interrupt_pin(interrupt_pin), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .oscillator_enable(), .cpu_run(cpu_run),
    .core_reset(), .program_counter(), .port_output_enable(),
    .latch_clear(), .retain_memory(retain_memory), .system_reg_clear(),
    .stack_pointer(), .control_bits(control_bits), .control_load(),
    .interval_load(interval_load), .interval_value(), .timer0_count(),
    .timer1_count(), .timer0_modulo(), .timer1_modulo(),
    .timer1_clear_signal(), .converter_result_register());

  function [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction

  task wr(input [3:0] a, input [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task rd(input [3:0] a, input [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    reg_read <= 1'b0;
  endtask

  // Bounded wait for a run level; a miss shows up as a compare failure.
  task wait_lvl(input logic v, input int lim);
    int n;
    n = 0;
    while (cpu_run !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
  endtask

  task final_report;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so check there.
  always @(posedge clock) begin
    if (rd_pend) begin
      `MRS_CHK(reg_rdata, exp_q.pop_front())
    end
    if (retain_memory === 1'b1) retain_cnt++;
    if (interval_load === 1'b1) iload_cnt++;
    rd_pend <= reg_read;
  end

  // Cuts a hang short; the whole run needs well under this.
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    final_report;
  end

  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    i_src.pin_pulse(1);
    wait_lvl(1'b1, 500);
    rd(4'h1, 8'h01);
    `MRS_CHK(control_bits, 8'h07)
    rd(4'h2, 8'h07);
    rd(4'h3, 8'h05);
    rd(4'h4, 8'h02);
    wr(4'h1, 8'h1F);
    rd(4'h1, 8'h00);
    rd(4'hF, 8'h00);
    rng = xs(rng);
    wr(4'h0, rng[7:0]);
    rd(4'h0, 8'h01);
    // Internal resets keep the control image but recopy the pin level.
    for (int k = 0; k < 3; k++) begin
      rng = xs(rng);
      interrupt_pin <= rng[0];
      repeat (4) @(posedge clock);
      mark = iload_cnt;
      @(posedge clock);
      case (k)
        0: watchdog_overflow <= 1'b1;
        1: stack_overflow <= 1'b1;
        default: stack_underflow <= 1'b1;
      endcase
      @(posedge clock);
      watchdog_overflow <= 1'b0;
      stack_overflow <= 1'b0;
      stack_underflow <= 1'b0;
      wait_lvl(1'b0, 20);
      wait_lvl(1'b1, 50);
      `MRS_CHK(cpu_run, 1'b1)
      rd(4'h1, codes[k]);
      wr(4'h1, 8'h1F);
      `MRS_CHK(control_bits, {4'h0, interrupt_pin, 3'h7})
      `MRS_CHK(iload_cnt - mark, k == 0)
    end
    // Supply dip in standby keeps memory; a pin reset when awake does not.
    standby <= 1'b1;
    mark = retain_cnt;
    i_src.supply_pulse(6);
    wait_lvl(1'b1, 500);
    standby <= 1'b0;
    rd(4'h1, 8'h02);
    wr(4'h1, 8'h1F);
    `MRS_CHK(retain_cnt > mark, 1'b1)
    mark = retain_cnt;
    i_src.pin_pulse(6);
    wait_lvl(1'b1, 500);
    rd(4'h1, 8'h01);
    `MRS_CHK(retain_cnt - mark, 0)
    repeat (3) @(posedge clock);
    // A block reset in mid-run must restart from hold with a fresh record.
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(4'h1, 8'h01);
    wait_lvl(1'b1, 500);
    `MRS_CHK(cpu_run, 1'b1)
    final_report;
  end
endmodule // mrs_reset_seq_tb
